// File: core/acrb_defs.vh
// Purpose: constants of the converter configuration register bank
// Assumes: 15-bit register addresses, 8-bit registers
// Notes:   definitions only
`ifndef ACRB_DEFS_VH
`define ACRB_DEFS_VH

// serial frame layout
`define ACRB_INSTR_LAST      4'hF
`define ACRB_BYTE_LAST       4'h7
`define ACRB_INSTR_RD_BIT    14
`define ACRB_ADDR_W          15

// first serial configuration register
`define ACRB_CFG_OFS         15'h0000
`define ACRB_CFG_RST         8'h00
`define ACRB_RST_HI_BIT      7
`define ACRB_DIR_BIT         5
`define ACRB_FOUR_BIT        4
`define ACRB_RST_LO_BIT      0

// bank address range
`define ACRB_BANK_FIRST      15'h005C
`define ACRB_BANK_LAST       15'h0071
`define ACRB_BANK_DEPTH      22

// offsets of the bank registers
`define ACRB_CH2_PAT0_OFS    15'h005C
`define ACRB_CH2_PAT1_OFS    15'h005D
`define ACRB_CH2_PAT2_OFS    15'h005E
`define ACRB_CH2_PAT3_OFS    15'h005F
`define ACRB_CH3_SPAN_OFS    15'h0060
`define ACRB_CH3_OFS0_OFS    15'h0061
`define ACRB_CH3_OFS1_OFS    15'h0062
`define ACRB_CH3_OFS2_OFS    15'h0063
`define ACRB_CH3_GAIN0_OFS   15'h0064
`define ACRB_CH3_GAIN1_OFS   15'h0065
`define ACRB_CH3_PHS0_OFS    15'h0066
`define ACRB_CH3_PHS1_OFS    15'h0067
`define ACRB_CH3_HI0_OFS     15'h0068
`define ACRB_CH3_HI1_OFS     15'h0069
`define ACRB_CH3_HI2_OFS     15'h006A
`define ACRB_CH3_LO0_OFS     15'h006B
`define ACRB_CH3_LO1_OFS     15'h006C
`define ACRB_CH3_LO2_OFS     15'h006D
`define ACRB_CH3_PAT0_OFS    15'h006E
`define ACRB_CH3_PAT1_OFS    15'h006F
`define ACRB_CH3_PAT2_OFS    15'h0070
`define ACRB_CH3_PAT3_OFS    15'h0071

// reset values (those that are not zero, then the zero default)
`define ACRB_CH2_PAT0_RST    8'h2A
`define ACRB_CH2_PAT1_RST    8'h3C
`define ACRB_CH2_PAT2_RST    8'hCE
`define ACRB_CH2_PAT3_RST    8'h2A
`define ACRB_CH3_SPAN_RST    8'h0F
`define ACRB_CH3_GAIN1_RST   8'h80
`define ACRB_CH3_HI0_RST     8'hF0
`define ACRB_CH3_HI1_RST     8'hFF
`define ACRB_CH3_HI2_RST     8'h7F
`define ACRB_CH3_LO2_RST     8'h80
`define ACRB_CH3_PAT0_RST    8'h2A
`define ACRB_CH3_PAT1_RST    8'h3C
`define ACRB_CH3_PAT2_RST    8'hCE
`define ACRB_CH3_PAT3_RST    8'h3A
`define ACRB_ZERO_RST        8'h00

// writable bits; reserved bits stay zero
`define ACRB_SPAN_MASK       8'h0F
`define ACRB_LOW_NIB_MASK    8'hF0
`define ACRB_FULL_MASK       8'hFF

`endif

// File: core/acrb_regbank.v
// Purpose: channel two/three calibration and test-pattern bytes
// Assumes: one write per cycle, read data registered
// Notes:   reserved bits are never stored and read zero
`timescale 1ns/1ps
`include "acrb_defs.vh"

module acrb_regbank (
   input  wire        clock_i,
   input  wire        resetn_i,
   input  wire        soft_reset_i,
   input  wire        wr_en_i,
   input  wire [14:0] addr_i,
   input  wire [7:0]  wr_data_i,
   output wire [7:0]  rd_data_o
);

   // default value of each byte
   function [7:0] rst_val;
      input [14:0] a;
      begin
         case (a)
            `ACRB_CH2_PAT0_OFS: rst_val = `ACRB_CH2_PAT0_RST;
            `ACRB_CH2_PAT1_OFS: rst_val = `ACRB_CH2_PAT1_RST;
            `ACRB_CH2_PAT2_OFS: rst_val = `ACRB_CH2_PAT2_RST;
            `ACRB_CH2_PAT3_OFS: rst_val = `ACRB_CH2_PAT3_RST;
            `ACRB_CH3_SPAN_OFS: rst_val = `ACRB_CH3_SPAN_RST;
            `ACRB_CH3_GAIN1_OFS: rst_val = `ACRB_CH3_GAIN1_RST;
            `ACRB_CH3_HI0_OFS: rst_val = `ACRB_CH3_HI0_RST;
            `ACRB_CH3_HI1_OFS: rst_val = `ACRB_CH3_HI1_RST;
            `ACRB_CH3_HI2_OFS: rst_val = `ACRB_CH3_HI2_RST;
            `ACRB_CH3_LO2_OFS: rst_val = `ACRB_CH3_LO2_RST;
            `ACRB_CH3_PAT0_OFS: rst_val = `ACRB_CH3_PAT0_RST;
            `ACRB_CH3_PAT1_OFS: rst_val = `ACRB_CH3_PAT1_RST;
            `ACRB_CH3_PAT2_OFS: rst_val = `ACRB_CH3_PAT2_RST;
            `ACRB_CH3_PAT3_OFS: rst_val = `ACRB_CH3_PAT3_RST;
            default: rst_val = `ACRB_ZERO_RST;
         endcase
      end
   endfunction

   // writable bits of each byte
   function [7:0] wr_mask;
      input [14:0] a;
      begin
         case (a)
            `ACRB_CH3_SPAN_OFS: wr_mask = `ACRB_SPAN_MASK;
            `ACRB_CH3_OFS0_OFS: wr_mask = `ACRB_LOW_NIB_MASK;
            `ACRB_CH3_HI0_OFS: wr_mask = `ACRB_LOW_NIB_MASK;
            `ACRB_CH3_LO0_OFS: wr_mask = `ACRB_LOW_NIB_MASK;
            default: wr_mask = `ACRB_FULL_MASK;
         endcase
      end
   endfunction

   wire [7:0]  byte_w [0:`ACRB_BANK_DEPTH-1];
   wire [14:0] index_w = addr_i - `ACRB_BANK_FIRST;
   wire        in_bank_w = (addr_i >= `ACRB_BANK_FIRST) &&
                           (addr_i <= `ACRB_BANK_LAST);
   reg  [7:0]  rd_data_q;

   // one storage byte per address, low byte at the low address
   genvar gi;
   generate
      for (gi = 0; gi < `ACRB_BANK_DEPTH; gi = gi + 1) begin : g_byte
         localparam [31:0] ADDR_FULL = `ACRB_BANK_FIRST + gi;
         localparam [14:0] ADDR      = ADDR_FULL[14:0];
         reg [7:0] val_q;
         always @(posedge clock_i or negedge resetn_i) begin
            if (!resetn_i) begin
               val_q <= rst_val(ADDR);
            end else if (soft_reset_i) begin
               val_q <= rst_val(ADDR);
            end else if (wr_en_i && (addr_i == ADDR)) begin
               val_q <= wr_data_i & wr_mask(ADDR);
            end
         end
         assign byte_w[gi] = val_q;
      end
   endgenerate

   // registered read, zero outside the bank
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_data_q <= 8'h00;
      end else if (in_bank_w) begin
         rd_data_q <= byte_w[index_w[4:0]];
      end else begin
         rd_data_q <= 8'h00;
      end
   end

   assign rd_data_o = rd_data_q;

endmodule // acrb_regbank

// File: core/acrb_top.v
// Purpose: serial configuration slave with config byte and channel bank
// Assumes: serial clock half period of at least four clock_i cycles;
//          mode 0 framing, 16-bit instruction then data bytes, MSB first;
//          the redirect input already lives on the clock_i domain
// Notes:   pins pass two flip-flops; read bits change on falling edges;
//          a partial byte at select rise is dropped, nothing is stored;
//          a direction bit written in a frame first steers the step after the next byte;
//          the bank read is registered, so the fall that launches a
//          byte must come two or more cycles after the address steps;
//          only the data phase of a read frame drives any pin
//
// Contract
// - soft reset only when one write sets both reset flags together
// - soft reset restores defaults but keeps direction and four-wire bits
// - direction bit 0: address steps down after each streamed data byte
// - direction bit 1: address steps up after each streamed data byte
// - four-wire bit 0: data both ways on bidir pin, out pin released
// - four-wire bit 1: reads on out pin, or lane zero when redirected
`timescale 1ns/1ps
`include "acrb_defs.vh"

module acrb_top (
   input  wire clock_i,
   input  wire resetn_i,
   input  wire config_chip_select_n_i,
   input  wire config_serial_clock_i,
   input  wire config_serial_bidir_pin_i,
   output wire config_serial_bidir_pin_o,
   output wire config_serial_bidir_pin_oe_o,
   output wire config_serial_out_pin_o,
   output wire config_serial_out_pin_oe_o,
   input  wire config_readback_lane_redirect_i,
   output wire conversion_output_lane_zero_o,
   output wire conversion_output_lane_zero_oe_o,
   output wire four_wire_enable_o,
   output wire address_ascending_o,
   output wire soft_reset_pulse_o
);

   // frame phases
   localparam PH_IDLE  = 2'b00;
   localparam PH_INSTR = 2'b01;
   localparam PH_WRITE = 2'b10;
   localparam PH_READ  = 2'b11;

   // pin synchronisers: [0] select, [1] clock, [2] data in
   reg  [2:0]  sync1_q;
   reg  [2:0]  sync2_q;
   reg         sclk_dly_q;
   wire [2:0]  pins_w = {config_serial_bidir_pin_i,
                         config_serial_clock_i,
                         config_chip_select_n_i};

   // frame state
   reg  [1:0]  phase_q;
   reg  [3:0]  cnt_q;
   reg  [15:0] shift_q;
   reg  [14:0] addr_q;
   reg  [7:0]  tx_q;

   // first configuration register
   reg         rst_hi_q;
   reg         rst_lo_q;
   reg         dir_q;
   reg         four_q;
   reg         soft_rst_q;

   // pin drivers
   reg         bidir_q;
   reg         bidir_oe_q;
   reg         out_q;
   reg         out_oe_q;
   reg         lane_q;
   reg         lane_oe_q;

   // synced pin views and serial clock edges
   wire        cs_n_w = sync2_q[0];
   wire        din_w  = sync2_q[2];
   wire        rise_w = sync2_q[1] & ~sclk_dly_q;
   wire        fall_w = ~sync2_q[1] & sclk_dly_q;

   // byte completion and write decode
   wire        byte_end_w = rise_w && (cnt_q == `ACRB_BYTE_LAST);
   wire [7:0]  wr_byte_w = {shift_q[6:0], din_w};
   wire        wr_done_w = (phase_q == PH_WRITE) && byte_end_w && !cs_n_w;
   wire        cfg_hit_w = (addr_q == `ACRB_CFG_OFS);
   wire        bank_wr_w = wr_done_w && !cfg_hit_w;

   // read path and reset event
   wire        rd_fall_w = fall_w && (phase_q == PH_READ) && !cs_n_w;
   wire        soft_evt_w;
   wire [7:0]  bank_rd_w;
   wire [7:0]  cfg_byte_w;
   wire [7:0]  rd_byte_w;
   wire        next_bit_w;

   // next streamed address
   function [14:0] step_addr;
      input [14:0] a;
      input        up;
      begin
         if (up) begin
            step_addr = a + 15'h0001;
         end else begin
            step_addr = a - 15'h0001;
         end
      end
   endfunction

   // two flip-flops on every pin input
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
         always @(posedge clock_i or negedge resetn_i) begin
            if (!resetn_i) begin
               // idle levels: select high, clock low, data high
               sync1_q[gi] <= (gi == 1) ? 1'b0 : 1'b1;
               sync2_q[gi] <= (gi == 1) ? 1'b0 : 1'b1;
            end else begin
               sync1_q[gi] <= pins_w[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   // delayed serial clock for edge detection
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sclk_dly_q <= 1'b0;
      end else begin
         sclk_dly_q <= sync2_q[1];
      end
   end

   // both reset flags in one write
   assign soft_evt_w = wr_done_w && cfg_hit_w &&
                       wr_byte_w[`ACRB_RST_HI_BIT] &&
                       wr_byte_w[`ACRB_RST_LO_BIT];

   // first configuration register
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_hi_q <= 1'b0;
         rst_lo_q <= 1'b0;
         dir_q    <= 1'b0;
         four_q   <= 1'b0;
      end else if (soft_evt_w) begin
         // flags clear, mode bits hold their values
         rst_hi_q <= 1'b0;
         rst_lo_q <= 1'b0;
      end else if (wr_done_w && cfg_hit_w) begin
         // plain write of the config byte
         rst_hi_q <= wr_byte_w[`ACRB_RST_HI_BIT];
         rst_lo_q <= wr_byte_w[`ACRB_RST_LO_BIT];
         dir_q    <= wr_byte_w[`ACRB_DIR_BIT];
         four_q   <= wr_byte_w[`ACRB_FOUR_BIT];
      end
   end

   // one-cycle marker of a software reset
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= soft_evt_w;
      end
   end

   // config byte as read back, reserved bits zero
   assign cfg_byte_w = {rst_hi_q, 1'b0, dir_q, four_q, 3'b000, rst_lo_q};

   // channel bank
   acrb_regbank u_bank (
      .clock_i      (clock_i),
      .resetn_i     (resetn_i),
      .soft_reset_i (soft_evt_w),
      .wr_en_i      (bank_wr_w),
      .addr_i       (addr_q),
      .wr_data_i    (wr_byte_w),
      .rd_data_o    (bank_rd_w)
   );

   // read source and the bit launched at the next fall
   assign rd_byte_w  = cfg_hit_w ? cfg_byte_w : bank_rd_w;
   assign next_bit_w = (cnt_q == 4'h0) ? rd_byte_w[7] : tx_q[7];

   // frame sequencer, sampled on serial clock rises
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         phase_q <= PH_IDLE;
         cnt_q   <= 4'h0;
         shift_q <= 16'h0000;
         addr_q  <= 15'h0000;
      end else if (cs_n_w) begin
         phase_q <= PH_IDLE;
         cnt_q   <= 4'h0;
      end else begin
         case (phase_q)
            // select seen low, wait for the first rise
            PH_IDLE: begin
               phase_q <= PH_INSTR;
               cnt_q   <= 4'h0;
            end
            // sixteen instruction bits, read flag first
            PH_INSTR: begin
               if (rise_w) begin
                  shift_q <= {shift_q[14:0], din_w};
                  cnt_q   <= cnt_q + 4'h1;
                  if (cnt_q == `ACRB_INSTR_LAST) begin
                     addr_q  <= {shift_q[13:0], din_w};
                     phase_q <= shift_q[`ACRB_INSTR_RD_BIT] ?
                                PH_READ : PH_WRITE;
                  end
               end
            end
            // data bytes, stored on the eighth rise
            PH_WRITE: begin
               if (rise_w) begin
                  shift_q <= {shift_q[14:0], din_w};
                  cnt_q   <= cnt_q + 4'h1;
                  if (byte_end_w) begin
                     cnt_q  <= 4'h0;
                     addr_q <= step_addr(addr_q, dir_q);
                  end
               end
            end
            // read bytes, address steps on the eighth rise
            default: begin
               if (rise_w) begin
                  cnt_q <= cnt_q + 4'h1;
                  if (byte_end_w) begin
                     cnt_q  <= 4'h0;
                     addr_q <= step_addr(addr_q, dir_q);
                  end
               end
            end
         endcase
      end
   end

   // read shifter, advanced on serial clock falls
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_q <= 8'h00;
      end else if (rd_fall_w) begin
         if (cnt_q == 4'h0) begin
            tx_q <= {rd_byte_w[6:0], 1'b0};
         end else begin
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // pin steering by wire mode
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bidir_q    <= 1'b0;
         bidir_oe_q <= 1'b0;
         out_q      <= 1'b0;
         out_oe_q   <= 1'b0;
         lane_q     <= 1'b0;
         lane_oe_q  <= 1'b0;
      end else if (cs_n_w) begin
         bidir_oe_q <= 1'b0;
         out_oe_q   <= 1'b0;
         lane_oe_q  <= 1'b0;
      end else if (rd_fall_w) begin
         if (!four_q) begin
            // three-wire: bit goes out on the bidir pin
            bidir_q    <= next_bit_w;
            bidir_oe_q <= 1'b1;
            out_oe_q   <= 1'b0;
            lane_oe_q  <= 1'b0;
         end else if (config_readback_lane_redirect_i) begin
            // four-wire, redirected to lane zero
            lane_q     <= next_bit_w;
            lane_oe_q  <= 1'b1;
            bidir_oe_q <= 1'b0;
            out_oe_q   <= 1'b0;
         end else begin
            // four-wire: dedicated out pin
            out_q      <= next_bit_w;
            out_oe_q   <= 1'b1;
            bidir_oe_q <= 1'b0;
            lane_oe_q  <= 1'b0;
         end
      end
   end

   // all outputs straight from flip-flops
   assign config_serial_bidir_pin_o        = bidir_q;
   assign config_serial_bidir_pin_oe_o     = bidir_oe_q;
   assign config_serial_out_pin_o          = out_q;
   assign config_serial_out_pin_oe_o       = out_oe_q;
   assign conversion_output_lane_zero_o    = lane_q;
   assign conversion_output_lane_zero_oe_o = lane_oe_q;
   assign four_wire_enable_o               = four_q;
   assign address_ascending_o              = dir_q;
   assign soft_reset_pulse_o               = soft_rst_q;

endmodule // acrb_top

// File: bench/acrb_top_asserts.sv
// Purpose: port-level checks bound to acrb_top
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bind statement follows the module
`timescale 1ns/1ps
module acrb_top_asserts (
   input logic clock_i,
   input logic resetn_i,
   input logic config_chip_select_n_i,
   input logic config_serial_bidir_pin_oe_o,
   input logic config_serial_out_pin_oe_o,
   input logic conversion_output_lane_zero_oe_o,
   input logic four_wire_enable_o,
   input logic address_ascending_o,
   input logic soft_reset_pulse_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   // frame end and released read drivers
   sequence s_sel_rise;
      $rose(config_chip_select_n_i);
   endsequence
   sequence s_quiet;
      !(config_serial_bidir_pin_oe_o || config_serial_out_pin_oe_o ||
        conversion_output_lane_zero_oe_o);
   endsequence
   a_out_released: assert property (!four_wire_enable_o |->
      !config_serial_out_pin_oe_o && !conversion_output_lane_zero_oe_o)
      else $error("out pin or lane driven in 3-wire mode");
   a_bidir_quiet: assert property (four_wire_enable_o |->
      !config_serial_bidir_pin_oe_o)
      else $error("bidir pin driven in 4-wire mode");
   a_lanes_exclusive: assert property (
      !(config_serial_out_pin_oe_o && conversion_output_lane_zero_oe_o))
      else $error("out pin and lane zero driven together");
   a_pulse_single: assert property (soft_reset_pulse_o |=>
      !soft_reset_pulse_o)
      else $error("soft reset pulse longer than one cycle");
   a_pulse_in_frame: assert property (soft_reset_pulse_o |->
      !config_chip_select_n_i)
      else $error("soft reset outside a write frame");
   a_reset_keeps_mode: assert property (soft_reset_pulse_o |->
      four_wire_enable_o == $past(four_wire_enable_o, 2) &&
      address_ascending_o == $past(address_ascending_o, 2))
      else $error("soft reset changed mode bits");
   a_mode_in_frame: assert property (($changed(address_ascending_o) ||
      $changed(four_wire_enable_o)) |-> !config_chip_select_n_i)
      else $error("mode bit changed outside a frame");
   a_drive_ends: assert property (s_sel_rise |-> ##[1:6] s_quiet)
      else $error("read driver not released after frame");
   a_oe_in_frame: assert property ($rose(config_serial_bidir_pin_oe_o)
      |-> !config_chip_select_n_i)
      else $error("bidir drive started outside a frame");
endmodule // acrb_top_asserts

bind acrb_top acrb_top_asserts u_chk (
   .clock_i                          (clock_i),
   .resetn_i                         (resetn_i),
   .config_chip_select_n_i           (config_chip_select_n_i),
   .config_serial_bidir_pin_oe_o     (config_serial_bidir_pin_oe_o),
   .config_serial_out_pin_oe_o       (config_serial_out_pin_oe_o),
   .conversion_output_lane_zero_oe_o (conversion_output_lane_zero_oe_o),
   .four_wire_enable_o               (four_wire_enable_o),
   .address_ascending_o              (address_ascending_o),
   .soft_reset_pulse_o               (soft_reset_pulse_o)
);

// File: bench/acrb_host_model.sv
// Purpose: serial configuration host driving acrb_top frames
// Assumes: half period of five clock cycles, mode 0, msb first
// Notes:   data_q holds bytes to send and bytes read back
`timescale 1ns/1ps
module acrb_host_model (
   input  logic clock_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic mosi_o,
   output logic mosi_oe_o,
   input  logic miso_i
);
   logic [7:0] data_q [0:31];
   // idle bus: select high, clock low, data released
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      mosi_o = 1'b0;
      mosi_oe_o = 1'b0;
   end
   task automatic half();
      repeat (5) @(negedge clock_i);
   endtask
   // one frame: instruction then n bytes; host lets go of data on reads
   task automatic frame(input logic rd, input logic [14:0] addr,
                        input int n);
      logic [15:0] ins;
      ins = {rd, addr};
      cs_n_o = 1'b0;
      mosi_oe_o = 1'b1;
      for (int i = 0; i < 16 + 8 * n; i++) begin
         if (i < 16) mosi_o = ins[15 - i];
         else if (rd) mosi_oe_o = 1'b0;
         else mosi_o = data_q[(i - 16) / 8][7 - (i % 8)];
         half();
         sclk_o = 1'b1;
         if (rd && i >= 16) data_q[(i - 16) / 8][7 - (i % 8)] = miso_i;
         half();
         sclk_o = 1'b0;
      end
      mosi_oe_o = 1'b0;
      half();
      cs_n_o = 1'b1; // select rises only after whole bytes, never mid-byte
      repeat (8) @(negedge clock_i);
   endtask
endmodule // acrb_host_model

// File: bench/acrb_top_tb_top.sv
// Purpose: self-checking bench for acrb_top
// Assumes: host model drives the serial pins
// Notes:   random bank data from an lfsr seeded 32'hA469
`timescale 1ns/1ps
`include "acrb_defs.vh"
module acrb_top_tb_top;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic redirect = 1'b0;
   logic tgl_q = 1'b0;
   logic [31:0] lfsr_q = 32'hA469;
   int error_cnt = 0;
   int cmp_count = 0;
   int pulse_cnt = 0;
   logic [2:0] oe_seen = 3'b000;
   logic [7:0] mdl [0:21];
   logic [7:0] rst_tab [0:21] = '{8'h2A, 8'h3C, 8'hCE, 8'h2A, 8'h0F,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'hF0, 8'hFF,
      8'h7F, 8'h00, 8'h00, 8'h80, 8'h2A, 8'h3C, 8'hCE, 8'h3A};
   wire cs_n, sclk, mosi, mosi_oe, bd_o, bd_oe, op_o, op_oe;
   wire l0_o, l0_oe, fw, asc, pulse;
   // wire levels; released lines toggle so stale data cannot pass
   wire bidir = mosi_oe ? mosi : bd_oe ? bd_o : tgl_q;
   wire rd_line = bd_oe ? bd_o : op_oe ? op_o : l0_oe ? l0_o : tgl_q;
   always #10 clock_i = ~clock_i;
   always @(negedge clock_i) tgl_q <= ~tgl_q;
   always @(posedge clock_i) if (pulse === 1'b1) pulse_cnt++;
   // which read drivers were on during a frame: bidir, out pin, lane zero
   always @(posedge clock_i)
      oe_seen <= oe_seen | {bd_oe === 1'b1, op_oe === 1'b1, l0_oe === 1'b1};
   acrb_host_model host (.clock_i(clock_i), .cs_n_o(cs_n), .sclk_o(sclk),
      .mosi_o(mosi), .mosi_oe_o(mosi_oe), .miso_i(rd_line));
   acrb_top dut (
      .clock_i                          (clock_i),
      .resetn_i                         (resetn_i),
      .config_chip_select_n_i           (cs_n),
      .config_serial_clock_i            (sclk),
      .config_serial_bidir_pin_i        (bidir),
      .config_serial_bidir_pin_o        (bd_o),
      .config_serial_bidir_pin_oe_o     (bd_oe),
      .config_serial_out_pin_o          (op_o),
      .config_serial_out_pin_oe_o       (op_oe),
      .config_readback_lane_redirect_i  (redirect),
      .conversion_output_lane_zero_o    (l0_o),
      .conversion_output_lane_zero_oe_o (l0_oe),
      .four_wire_enable_o               (fw),
      .address_ascending_o              (asc),
      .soft_reset_pulse_o               (pulse)
   );
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // writable bits of a bank byte
   function automatic logic [7:0] msk(input int i);
      return i == 4 ? 8'h0F : (i == 5 || i == 12 || i == 15) ? 8'hF0 : 8'hFF;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr1(input logic [7:0] d);
      host.data_q[0] = d;
      host.frame(1'b0, `ACRB_CFG_OFS, 1);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // watchdog: the run needs about 11100 cycles, allow 30000
   initial begin
      #600000;
      error_cnt++;
      test_done();
   end
   initial begin
      repeat (5) @(negedge clock_i);
      resetn_i = 1'b1;
      repeat (4) @(negedge clock_i);
      // defaults, descending stream from the top of the bank
      oe_seen = 3'b000;
      host.frame(1'b1, `ACRB_BANK_LAST, 22);
      for (int i = 0; i < 22; i++) chk(host.data_q[i], rst_tab[21 - i]);
      chk({5'h00, oe_seen}, 8'h04);
      $display("test defaults done");
      // ascending random stream write and read back, 3-wire
      wr1(8'h20);
      chk({7'h00, asc}, 8'h01);
      for (int i = 0; i < 22; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         host.data_q[i] = lfsr_q[7:0];
         mdl[i] = lfsr_q[7:0] & msk(i);
      end
      host.frame(1'b0, `ACRB_BANK_FIRST, 22);
      host.frame(1'b1, `ACRB_BANK_FIRST, 22);
      for (int i = 0; i < 22; i++) chk(host.data_q[i], mdl[i]);
      // stream across unmapped bytes into the bank
      host.frame(1'b1, 15'h005A, 3);
      chk(host.data_q[0], 8'h00);
      chk(host.data_q[1], 8'h00);
      chk(host.data_q[2], mdl[0]);
      $display("test stream done");
      // four-wire reads on out pin then on lane zero
      wr1(8'h30);
      chk({7'h00, fw}, 8'h01);
      for (int r = 0; r < 2; r++) begin
         redirect = r[0];
         oe_seen = 3'b000;
         host.frame(1'b1, 15'h0064, 2);
         chk(host.data_q[0], mdl[8]);
         chk(host.data_q[1], mdl[9]);
         chk({5'h00, oe_seen}, r[0] ? 8'h01 : 8'h02);
      end
      $display("test four-wire done");
      // each flag alone leaves the bank untouched
      wr1(8'hB0);
      wr1(8'h31);
      host.frame(1'b1, 15'h0064, 1);
      chk(host.data_q[0], mdl[8]);
      chk(pulse_cnt[7:0], 8'h00);
      // both flags: defaults back, mode bits kept
      wr1(8'h81);
      chk(pulse_cnt[7:0], 8'h01);
      chk({6'h00, fw, asc}, 8'h03);
      host.frame(1'b1, `ACRB_BANK_FIRST, 22);
      for (int i = 0; i < 22; i++) chk(host.data_q[i], rst_tab[i]);
      host.frame(1'b1, `ACRB_CFG_OFS, 1);
      chk(host.data_q[0], 8'h30);
      $display("test soft reset done");
      // hardware reset mid-run: mode bits and a written byte to default
      host.data_q[0] = 8'h55;
      host.frame(1'b0, 15'h0066, 1);
      resetn_i = 1'b0;
      repeat (2) @(negedge clock_i);
      resetn_i = 1'b1;
      repeat (4) @(negedge clock_i);
      chk({6'h00, fw, asc}, 8'h00);
      host.frame(1'b1, 15'h0066, 1);
      chk(host.data_q[0], rst_tab[10]);
      $display("test hard reset done");
      test_done();
   end
endmodule // acrb_top_tb_top
